// ### core/ieb_top.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ieb_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [ieb_pkg::NSRC-1:0] srcReq,
    output logic [15:0] regRdData,
    output logic [ieb_pkg::NSRC-1:0] cpuReq,
    output logic cpuReqAny,
    output logic [2:0] cpuLevel
);

    ieb_pkg::ieb_bus_t bus;
    logic [15:0] en0;
    logic [15:0] en1;
    logic [15:0] en2;
    logic [15:0] flag0;
    logic [15:0] flag1;
    logic [15:0] flag2;
    logic [ieb_pkg::NSRC-1:0] enAll;
    logic [ieb_pkg::NSRC-1:0] flagAll;
    logic [ieb_pkg::NSRC-1:0] next_cpuReq;
    logic [ieb_pkg::NSRC*3-1:0] prioAll;
    logic [15:0] prioWord;
    logic [ieb_pkg::NSRC-1:0] enGate;
    logic [15:0] rdHold;
    logic [2:0] next_level;
    logic wrEn0;
    logic wrEn1;
    logic wrEn2;
    logic wrPrio;

    // One named enable per source, so each gate can be traced by name.
    logic adcDoneEn;
    logic serial1TxEn;
    logic serial1RxEn;
    logic spiPort1DoneEn;
    logic spiPort1FaultEn;
    logic timer3En;
    logic timer2En;
    logic compare2En;
    logic capture2En;
    logic timer1En;
    logic compare1En;
    logic capture1En;
    logic extIrq0En;
    logic serial2TxEn;
    logic serial2RxEn;
    logic extIrq2En;
    logic timer5En;
    logic timer4En;
    logic compare4En;
    logic compare3En;
    logic capture8En;
    logic capture7En;
    logic extIrq1En;
    logic pinChangeEn;
    logic comparatorEn;
    logic i2cPort1MasterEn;
    logic i2cPort1SlaveEn;
    logic parallelPortEn;
    logic compare8En;
    logic compare7En;
    logic compare6En;
    logic compare5En;
    logic capture6En;
    logic capture5En;
    logic capture4En;
    logic capture3En;
    logic spiPort2EventEn;
    logic spiPort2FaultEn;

    // The register request travels as one bundle.
    assign bus.wrStb = regWrStb;
    assign bus.rdStb = regRdStb;
    assign bus.addr = regAddr;
    assign bus.wrData = regWrData;

    // Write decode of the enable banks and the priority window.
    assign wrEn0 = bus.wrStb && bus.addr == ieb_pkg::ADDR_ENABLE0;
    assign wrEn1 = bus.wrStb && bus.addr == ieb_pkg::ADDR_ENABLE1;
    assign wrEn2 = bus.wrStb && bus.addr == ieb_pkg::ADDR_ENABLE2;
    assign wrPrio = bus.wrStb && bus.addr[3:2] == ieb_pkg::ADDR_PRIO_BASE[3:2];

    ieb_bank_reg #(.MASK(ieb_pkg::MASK0)) uBank0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(wrEn0),
        .wrData(bus.wrData),
        .value(en0)
    );

    ieb_bank_reg #(.MASK(ieb_pkg::MASK1)) uBank1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(wrEn1),
        .wrData(bus.wrData),
        .value(en1)
    );

    ieb_bank_reg #(.MASK(ieb_pkg::MASK2)) uBank2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(wrEn2),
        .wrData(bus.wrData),
        .value(en2)
    );

    // Priority words hold four 3-bit codes each, at bit offsets 0,4,8,12.
    // The prio window is four words; word index picks from 12 stored words
    // through the two low address bits of the window plus a page select.
    logic [1:0] prioPage;
    logic [5:0] prioIdx;

    // Page register selects which group of four words the window shows.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prioPage <= 2'd0;
        end else if (bus.wrStb && bus.addr == ieb_pkg::ADDR_STATUS) begin
            prioPage <= bus.wrData[1:0];
        end
    end

    assign prioIdx = {2'b00, prioPage, bus.addr[1:0]};

    ieb_prio_mem uPrio (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(wrPrio),
        .wrIdx(prioIdx),
        .wrData({bus.wrData[14:12], bus.wrData[10:8],
                 bus.wrData[6:4], bus.wrData[2:0]}),
        .rdIdx(prioIdx),
        .rdData(),
        .allPrio(prioAll)
    );

    // sticky flags
    // A request in the clear cycle wins, so no event is lost.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag0 <= ieb_pkg::RESET_FLAG;
            flag1 <= ieb_pkg::RESET_FLAG;
            flag2 <= ieb_pkg::RESET_FLAG;
        end else begin
            flag0 <= (bus.addr == ieb_pkg::ADDR_FLAG0 && bus.wrStb ?
                bus.wrData : flag0) & ieb_pkg::MASK0 | srcReq[15:0]
                & ieb_pkg::MASK0;
            flag1 <= (bus.addr == ieb_pkg::ADDR_FLAG1 && bus.wrStb ?
                bus.wrData : flag1) & ieb_pkg::MASK1 | srcReq[31:16]
                & ieb_pkg::MASK1;
            flag2 <= (bus.addr == ieb_pkg::ADDR_FLAG2 && bus.wrStb ?
                bus.wrData : flag2) & ieb_pkg::MASK2 | srcReq[47:32]
                & ieb_pkg::MASK2;
        end
    end

    assign enAll = {en2, en1, en0};
    assign flagAll = {flag2, flag1, flag0};

    // Bank 0 upper half: converter, serial port 1, SPI port 1, timer 3.
    // bank 0 fields
    assign adcDoneEn = enAll[ieb_pkg::SRC_ADC_DONE];
    assign serial1TxEn = enAll[ieb_pkg::SRC_SERIAL1_TX];
    assign serial1RxEn = enAll[ieb_pkg::SRC_SERIAL1_RX];
    assign spiPort1DoneEn = enAll[ieb_pkg::SRC_SPI1_DONE];
    assign spiPort1FaultEn = enAll[ieb_pkg::SRC_SPI1_FAULT];
    assign timer3En = enAll[ieb_pkg::SRC_TIMER3];

    assign timer2En = enAll[ieb_pkg::SRC_TIMER2];
    assign compare2En = enAll[ieb_pkg::SRC_COMPARE2];
    assign capture2En = enAll[ieb_pkg::SRC_CAPTURE2];
    assign timer1En = enAll[ieb_pkg::SRC_TIMER1];
    assign compare1En = enAll[ieb_pkg::SRC_COMPARE1];
    assign capture1En = enAll[ieb_pkg::SRC_CAPTURE1];
    assign extIrq0En = enAll[ieb_pkg::SRC_EXT_IRQ0];

    assign serial2TxEn = enAll[ieb_pkg::SRC_SERIAL2_TX];
    assign serial2RxEn = enAll[ieb_pkg::SRC_SERIAL2_RX];
    assign extIrq2En = enAll[ieb_pkg::SRC_EXT_IRQ2];
    assign timer5En = enAll[ieb_pkg::SRC_TIMER5];
    assign timer4En = enAll[ieb_pkg::SRC_TIMER4];
    assign compare4En = enAll[ieb_pkg::SRC_COMPARE4];
    assign compare3En = enAll[ieb_pkg::SRC_COMPARE3];

    assign capture8En = enAll[ieb_pkg::SRC_CAPTURE8];
    assign capture7En = enAll[ieb_pkg::SRC_CAPTURE7];
    assign extIrq1En = enAll[ieb_pkg::SRC_EXT_IRQ1];
    assign pinChangeEn = enAll[ieb_pkg::SRC_PIN_CHANGE];
    assign comparatorEn = enAll[ieb_pkg::SRC_COMPARATOR];
    assign i2cPort1MasterEn = enAll[ieb_pkg::SRC_I2C1_MASTER];
    assign i2cPort1SlaveEn = enAll[ieb_pkg::SRC_I2C1_SLAVE];

    assign parallelPortEn = enAll[ieb_pkg::SRC_PARALLEL];
    assign compare8En = enAll[ieb_pkg::SRC_COMPARE8];
    assign compare7En = enAll[ieb_pkg::SRC_COMPARE7];
    assign compare6En = enAll[ieb_pkg::SRC_COMPARE6];
    assign compare5En = enAll[ieb_pkg::SRC_COMPARE5];
    assign capture6En = enAll[ieb_pkg::SRC_CAPTURE6];

    assign capture5En = enAll[ieb_pkg::SRC_CAPTURE5];
    assign capture4En = enAll[ieb_pkg::SRC_CAPTURE4];
    assign capture3En = enAll[ieb_pkg::SRC_CAPTURE3];
    assign spiPort2EventEn = enAll[ieb_pkg::SRC_SPI2_EVENT];
    assign spiPort2FaultEn = enAll[ieb_pkg::SRC_SPI2_FAULT];

    // spare gates stay closed
    // Only named sources reach the gate; a spare position is tied low
    // here as well, so a stuck spare bit can never raise a request.
    always_comb begin
        enGate = '0;
        enGate[ieb_pkg::SRC_ADC_DONE] = adcDoneEn;
        enGate[ieb_pkg::SRC_SERIAL1_TX] = serial1TxEn;
        enGate[ieb_pkg::SRC_SERIAL1_RX] = serial1RxEn;
        enGate[ieb_pkg::SRC_SPI1_DONE] = spiPort1DoneEn;
        enGate[ieb_pkg::SRC_SPI1_FAULT] = spiPort1FaultEn;
        enGate[ieb_pkg::SRC_TIMER3] = timer3En;
        enGate[ieb_pkg::SRC_TIMER2] = timer2En;
        enGate[ieb_pkg::SRC_COMPARE2] = compare2En;
        enGate[ieb_pkg::SRC_CAPTURE2] = capture2En;
        enGate[ieb_pkg::SRC_TIMER1] = timer1En;
        enGate[ieb_pkg::SRC_COMPARE1] = compare1En;
        enGate[ieb_pkg::SRC_CAPTURE1] = capture1En;
        enGate[ieb_pkg::SRC_EXT_IRQ0] = extIrq0En;
        enGate[ieb_pkg::SRC_SERIAL2_TX] = serial2TxEn;
        enGate[ieb_pkg::SRC_SERIAL2_RX] = serial2RxEn;
        enGate[ieb_pkg::SRC_EXT_IRQ2] = extIrq2En;
        enGate[ieb_pkg::SRC_TIMER5] = timer5En;
        enGate[ieb_pkg::SRC_TIMER4] = timer4En;
        enGate[ieb_pkg::SRC_COMPARE4] = compare4En;
        enGate[ieb_pkg::SRC_COMPARE3] = compare3En;
        enGate[ieb_pkg::SRC_CAPTURE8] = capture8En;
        enGate[ieb_pkg::SRC_CAPTURE7] = capture7En;
        enGate[ieb_pkg::SRC_EXT_IRQ1] = extIrq1En;
        enGate[ieb_pkg::SRC_PIN_CHANGE] = pinChangeEn;
        enGate[ieb_pkg::SRC_COMPARATOR] = comparatorEn;
        enGate[ieb_pkg::SRC_I2C1_MASTER] = i2cPort1MasterEn;
        enGate[ieb_pkg::SRC_I2C1_SLAVE] = i2cPort1SlaveEn;
        enGate[ieb_pkg::SRC_PARALLEL] = parallelPortEn;
        enGate[ieb_pkg::SRC_COMPARE8] = compare8En;
        enGate[ieb_pkg::SRC_COMPARE7] = compare7En;
        enGate[ieb_pkg::SRC_COMPARE6] = compare6En;
        enGate[ieb_pkg::SRC_COMPARE5] = compare5En;
        enGate[ieb_pkg::SRC_CAPTURE6] = capture6En;
        enGate[ieb_pkg::SRC_CAPTURE5] = capture5En;
        enGate[ieb_pkg::SRC_CAPTURE4] = capture4En;
        enGate[ieb_pkg::SRC_CAPTURE3] = capture3En;
        enGate[ieb_pkg::SRC_SPI2_EVENT] = spiPort2EventEn;
        enGate[ieb_pkg::SRC_SPI2_FAULT] = spiPort2FaultEn;
    end

    always_comb begin
        next_cpuReq = '0;
        next_level = ieb_pkg::PRIO_OFF;
        for (int i = 0; i < ieb_pkg::NSRC; i++) begin
            if (flagAll[i] && enGate[i] &&
                prioAll[i*3 +: 3] != ieb_pkg::PRIO_OFF) begin
                next_cpuReq[i] = 1'b1;
                if (prioAll[i*3 +: 3] > next_level) begin
                    next_level = prioAll[i*3 +: 3];
                end
            end
        end
    end

    // Registered request outputs toward the CPU.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpuReq <= '0;
            cpuReqAny <= 1'b0;
            cpuLevel <= ieb_pkg::PRIO_OFF;
        end else begin
            cpuReq <= next_cpuReq;
            cpuReqAny <= |next_cpuReq;
            cpuLevel <= next_level;
        end
    end

    // Priority word for the window, taken from the flat view so that it
    // can be registered at the strobe edge like every other register.
    // Pages past the last stored word read as zero.
    always_comb begin
        prioWord = 16'h0000;
        if (prioIdx < 6'd12) begin
            for (int k = 0; k < 4; k++) begin
                prioWord[k*4 +: 3] = prioAll[(prioIdx*4 + k)*3 +: 3];
            end
        end
    end

    // Read mux registered one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdHold <= 16'h0000;
        end else if (bus.rdStb) begin
            unique case (bus.addr)
                ieb_pkg::ADDR_ENABLE0: rdHold <= en0;
                ieb_pkg::ADDR_ENABLE1: rdHold <= en1;
                ieb_pkg::ADDR_ENABLE2: rdHold <= en2;
                ieb_pkg::ADDR_FLAG0: rdHold <= flag0;
                ieb_pkg::ADDR_FLAG1: rdHold <= flag1;
                ieb_pkg::ADDR_FLAG2: rdHold <= flag2;
                ieb_pkg::ADDR_STATUS: rdHold <= {9'h000, cpuReqAny,
                    cpuLevel, 1'b0, prioPage};
                default: begin
                    rdHold <= (bus.addr[3:2] ==
                        ieb_pkg::ADDR_PRIO_BASE[3:2]) ? prioWord : 16'h0000;
                end
            endcase
        end else begin
            rdHold <= 16'h0000;
        end
    end

    // Read data leave straight from the holding register.
    assign regRdData = rdHold;

endmodule : ieb_top

// ### core/ieb_pkg.sv
package ieb_pkg;

    // Register indices on the plain register port.
    localparam logic [3:0] ADDR_ENABLE0 = 4'h0;
    localparam logic [3:0] ADDR_ENABLE1 = 4'h1;
    localparam logic [3:0] ADDR_ENABLE2 = 4'h2;
    localparam logic [3:0] ADDR_FLAG0 = 4'h4;
    localparam logic [3:0] ADDR_FLAG1 = 4'h5;
    localparam logic [3:0] ADDR_FLAG2 = 4'h6;
    localparam logic [3:0] ADDR_PRIO_BASE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hF;

    // Implemented-bit masks of the three banks.
    localparam logic [15:0] MASK0 = 16'h3_FEF;
    localparam logic [15:0] MASK1 = 16'hF_EDF;
    localparam logic [15:0] MASK2 = 16'h3_FE3;
    localparam logic [15:0] RESET_ENABLE = 16'h0000;
    localparam logic [15:0] RESET_FLAG = 16'h0000;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_MAX = 3'h7;

    // Position of every source in the flat 48-bit request vector.
    localparam int SRC_EXT_IRQ0 = 0;
    localparam int SRC_CAPTURE1 = 1;
    localparam int SRC_COMPARE1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_CAPTURE2 = 5;
    localparam int SRC_COMPARE2 = 6;
    localparam int SRC_TIMER2 = 7;
    localparam int SRC_TIMER3 = 8;
    localparam int SRC_SPI1_FAULT = 9;
    localparam int SRC_SPI1_DONE = 10;
    localparam int SRC_SERIAL1_RX = 11;
    localparam int SRC_SERIAL1_TX = 12;
    localparam int SRC_ADC_DONE = 13;
    localparam int SRC_I2C1_SLAVE = 16;
    localparam int SRC_I2C1_MASTER = 17;
    localparam int SRC_COMPARATOR = 18;
    localparam int SRC_PIN_CHANGE = 19;
    localparam int SRC_EXT_IRQ1 = 20;
    localparam int SRC_CAPTURE7 = 22;
    localparam int SRC_CAPTURE8 = 23;
    localparam int SRC_COMPARE3 = 25;
    localparam int SRC_COMPARE4 = 26;
    localparam int SRC_TIMER4 = 27;
    localparam int SRC_TIMER5 = 28;
    localparam int SRC_EXT_IRQ2 = 29;
    localparam int SRC_SERIAL2_RX = 30;
    localparam int SRC_SERIAL2_TX = 31;
    localparam int SRC_SPI2_FAULT = 32;
    localparam int SRC_SPI2_EVENT = 33;
    localparam int SRC_CAPTURE3 = 37;
    localparam int SRC_CAPTURE4 = 38;
    localparam int SRC_CAPTURE5 = 39;
    localparam int SRC_CAPTURE6 = 40;
    localparam int SRC_COMPARE5 = 41;
    localparam int SRC_COMPARE6 = 42;
    localparam int SRC_COMPARE7 = 43;
    localparam int SRC_COMPARE8 = 44;
    localparam int SRC_PARALLEL = 45;

    localparam int NSRC = 48;
    localparam int PRIO_REGS = 4;

    // Register access request carried as one bundle.
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [3:0] addr;
        logic [15:0] wrData;
    } ieb_bus_t;

    // Bit mask of the bank that a bus index selects.
    function automatic logic [15:0] bankMask(input logic [1:0] bank);
        case (bank)
            2'd0: bankMask = MASK0;
            2'd1: bankMask = MASK1;
            2'd2: bankMask = MASK2;
            default: bankMask = 16'h0000;
        endcase
    endfunction : bankMask

endpackage : ieb_pkg

// ### core/ieb_bank_reg.sv
`timescale 1ns/1ps
// One 16-bit bank with an implemented-bit mask.
module ieb_bank_reg #(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    output logic [15:0] value
);

    // Masked bits never store a one, so they read as zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value <= ieb_pkg::RESET_ENABLE;
        end else if (wrEn) begin
            value <= wrData & MASK;
        end
    end

endmodule : ieb_bank_reg

// ### core/ieb_prio_mem.sv
`timescale 1ns/1ps
// Priority fields, four to a word, with registered read data.
module ieb_prio_mem (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [5:0] wrIdx,
    input wire logic [11:0] wrData,
    input wire logic [5:0] rdIdx,
    output logic [11:0] rdData,
    output logic [ieb_pkg::NSRC*3-1:0] allPrio
);

    logic [11:0] mem [0:11];

    // Storage of the priority words; all codes start disabled.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 12; i++) begin
                mem[i] <= 12'h000;
            end
        end else if (wrEn && wrIdx < 6'd12) begin
            mem[wrIdx[3:0]] <= wrData;
        end
    end

    // Registered read port.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData <= 12'h000;
        end else begin
            rdData <= (rdIdx < 6'd12) ? mem[rdIdx[3:0]] : 12'h000;
        end
    end

    // Flat view for the request gating.
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            allPrio[i*12 +: 12] = mem[i];
        end
    end

endmodule : ieb_prio_mem

// ### bench/ieb_src_model.sv
`timescale 1ns/1ps
// Peripheral event sources: each fire gives a one-cycle request pulse.
module ieb_src_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [5:0] idx,
    output logic [47:0] srcReq = 48'h0000_0000_0000
);
    // inputs already routed
    // External sources are taken as routed to a pin, else they never pulse.
    always @(posedge clk) begin
        srcReq <= fire ? 48'h0000_0000_0001 << idx : 48'h0000_0000_0000;
    end
endmodule : ieb_src_model

// ### bench/ieb_assertions.sv
`timescale 1ns/1ps
module ieb_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [47:0] srcReq,
    input wire logic [15:0] regRdData,
    input wire logic [47:0] cpuReq,
    input wire logic cpuReqAny,
    input wire logic [2:0] cpuLevel
);
    localparam logic [47:0] IMPL = 48'h3FE3_FEDF_3FEF;
    logic [47:0] enSh;
    logic [15:0] expRd;
    logic rdEn;
    logic rdOff;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the enables, masked so spare bits can never stick.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enSh <= '0;
        end else if (regWrStb && regAddr < 4'h3) begin
            enSh[16*regAddr[1:0] +: 16] <=
                regWrData & IMPL[16*regAddr[1:0] +: 16];
        end
    end
    // Expected read data, captured at the read strobe.
    always_ff @(posedge clk) begin
        expRd <= enSh[16*regAddr[1:0] +: 16];
        rdEn <= regRdStb && regAddr < 4'h3;
        rdOff <= regRdStb && (regAddr == 4'h3 || regAddr == 4'h7
            || (regAddr > 4'hB && regAddr != 4'hF));
    end
    a_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> cpuReq == '0 && regRdData == '0)
        else $error("outputs not clear after reset");
    a_read_idle: assert property (!$past(regRdStb) |-> regRdData == '0)
        else $error("read data outside its cycle");
    a_spare_quiet: assert property ((cpuReq & ~IMPL) == '0)
        else $error("request on a spare bit");
    a_block_off: assert property ((cpuReq & ~$past(enSh)) == '0)
        else $error("request passed a clear enable");
    a_enable_read: assert property (rdEn |-> regRdData == expRd)
        else $error("enable readback wrong");
    a_unmapped_zero: assert property (rdOff |-> regRdData == '0)
        else $error("unmapped read not zero");
    a_any_match: assert property (cpuReqAny == (cpuReq != '0))
        else $error("summary request disagrees");
    a_level_any: assert property ((cpuLevel != 3'h0) == cpuReqAny)
        else $error("level disagrees with request");
    c_any: cover property ($rose(cpuReqAny));
    c_drop: cover property ($fell(cpuReqAny));
    c_off: cover property (rdOff);
endmodule : ieb_assertions

bind ieb_top ieb_assertions chk_u (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .srcReq(srcReq), .regRdData(regRdData),
    .cpuReq(cpuReq), .cpuReqAny(cpuReqAny), .cpuLevel(cpuLevel));

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [47:0] IMPL = 48'h3FE3_FEDF_3FEF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic fire = 1'b0;
    logic [5:0] idx = 6'h00;
    logic [47:0] srcReq;
    logic [15:0] regRdData;
    logic [47:0] cpuReq;
    logic cpuReqAny;
    logic [2:0] cpuLevel;
    logic [47:0] rdv;
    logic [47:0] expReq;
    int fails = 0;
    int checked = 0;
    // System clock at 10 MHz.
    always #50 clk = ~clk;
    ieb_src_model src_u (.clk(clk), .fire(fire), .idx(idx),
        .srcReq(srcReq));
    ieb_top dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .srcReq(srcReq), .regRdData(regRdData), .cpuReq(cpuReq),
        .cpuReqAny(cpuReqAny), .cpuLevel(cpuLevel));
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask : wr
    // Read data is only valid in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1 rdv = 48'(regRdData);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk);
        fire <= 1'b1;
        idx <= i[5:0];
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic final_report;
        $display("Counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // Main sequence: registers, priorities, then every source in turn.
    initial begin
        expReq = 48'h0000_0000_0000;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int b = 0; b < 3; b++) begin
            rd(b[3:0]);
            chk(rdv, 48'h0000_0000_0000);
            wr(b[3:0], 16'hFFFF);
            rd(b[3:0]);
            chk(rdv, 48'(IMPL[16*b +: 16]));
        end
        for (int p = 0; p < 3; p++) begin
            wr(4'hF, p[15:0]);
            for (int w = 8; w < 12; w++) begin
                wr(w[3:0], 16'h7777);
            end
        end
        for (int i = 0; i < 48; i++) begin
            pulse(i);
            tick(3);
            expReq[i] = IMPL[i];
            chk(cpuReq, expReq);
        end
        chk(48'(cpuLevel), 48'h0000_0000_0007);
        rd(4'hF);
        chk(rdv, 48'h0000_0000_007A);
        rd(4'h4);
        chk(rdv, 48'(IMPL[15:0]));
        wr(4'h0, 16'h0000);
        tick(2);
        chk(cpuReq, IMPL & 48'hFFFF_FFFF_0000);
        wr(4'hF, 16'h0000);
        wr(4'h8, 16'h7770);
        wr(4'h0, 16'hFFFF);
        tick(2);
        chk(cpuReq, IMPL & 48'hFFFF_FFFF_FFFE);
        rd(4'h8);
        chk(rdv, 48'h0000_0000_7770);
        for (int f = 4; f < 7; f++) begin
            wr(f[3:0], 16'h0000);
        end
        tick(2);
        chk(cpuReq, 48'h0000_0000_0000);
        chk(48'(cpuReqAny), 48'h0000_0000_0000);
        rd(4'h3);
        chk(rdv, 48'h0000_0000_0000);
        final_report();
    end
    // Hang guard; the real run ends long before this.
    initial begin
        #5_000_000;
        fails++;
        final_report();
    end
endmodule : tb_top
